/* lane_group_clocking_control.sv */
// register bank for lane group clocking controls
`timescale 1ns/1ps
`default_nettype none
module lane_group_clocking_control (
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  input  wire logic [lane_group_pkg::ADDR_W-1:0]   riuAddr,
  input  wire logic                                riuWrEn,
  input  wire logic [lane_group_pkg::DATA_W-1:0]   riuWrData,
  output var  logic [lane_group_pkg::DATA_W-1:0]   riuRdData,
  input  wire logic                                calSerialWrEn,
  input  wire logic                                calSerialValue,
  input  wire logic                                fixedDelayCalDone,
  output var  logic                                rxGateEn,
  output var  logic                                txGateEn,
  output var  logic                                serialSampleEn,
  output var  logic                                invertRxClk,
  output var  logic                                negStrobeFromNeighbor,
  output var  logic                                posStrobeFromNeighbor,
  output var  logic [lane_group_pkg::TX_PHASE_W-1:0] txDataPhase,
  output var  logic                                rxClkPhaseNeg,
  output var  logic                                rxClkPhasePos
);
  import lane_group_pkg::*;

  typedef struct packed {
    logic [CTRLA_W-1:0]    controlA;
    logic [CTRLB_W-1:0]    controlB;
    logic                  readyStatus;
    logic [DATA_W-1:0]     rdData;
    logic                  rxGate;
    logic                  txGate;
    logic                  serialSample;
    logic                  invertRx;
    logic                  negNeighbor;
    logic                  posNeighbor;
    logic [TX_PHASE_W-1:0] txPhase;
    logic                  rxPhaseNeg;
    logic                  rxPhasePos;
  } bankState_t;

  localparam bankState_t BANK_RESET = '{
    controlA:     CTRLA_RESET,
    controlB:     CTRLB_RESET,
    readyStatus:  1'b0,
    rdData:       UNMAPPED_READ,
    rxGate:       CTRLA_RESET[RX_GATE_POS],
    txGate:       CTRLA_RESET[TX_GATE_POS],
    serialSample: CTRLA_RESET[SERIAL_SAMPLE_POS],
    invertRx:     CTRLA_RESET[INVERT_RX_CLK_POS],
    negNeighbor:  CTRLA_RESET[NEG_NEIGHBOR_POS],
    posNeighbor:  CTRLA_RESET[POS_NEIGHBOR_POS],
    txPhase:      CTRLB_RESET[TX_PHASE_MSB:TX_PHASE_LSB],
    rxPhaseNeg:   CTRLB_RESET[RX_PHASE_NEG_POS],
    rxPhasePos:   CTRLB_RESET[RX_PHASE_POS_POS]
  };

  bankState_t state_q;
  bankState_t state_d;
  logic       fixedDelayReady;

  // the done level comes from calibration logic on another timing path
  level_sync3 readySync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (fixedDelayCalDone),
    .syncOut (fixedDelayReady)
  );

  // read view of one register; reserved bits read as zero
  function automatic logic [DATA_W-1:0] regView(
    input logic [ADDR_W-1:0]  addr,
    input logic [CTRLA_W-1:0] ctrlA,
    input logic [CTRLB_W-1:0] ctrlB,
    input logic               ready
  );
    logic [DATA_W-1:0] view;
    view = UNMAPPED_READ;
    case (addr)
      LANE_GROUP_CONTROL_A_OFS: view[CTRLA_W-1:0] = ctrlA;
      LANE_GROUP_CONTROL_B_OFS: view[CTRLB_W-1:0] = ctrlB;
      CAL_STATUS_OFS:           view[FIXED_DELAY_READY_POS] = ready;
      default:                  view = UNMAPPED_READ;
    endcase
    return view;
  endfunction : regView

  function automatic logic isWrite(
    input logic              wrEn,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    return wrEn && (addr == target);
  endfunction : isWrite

  always_comb begin
    state_d = state_q;
    // calibration may flip the serial bit during its first pass; a later
    // register write is how the controller restores its own choice
    if (calSerialWrEn) begin
      state_d.controlA[SERIAL_SAMPLE_POS] = calSerialValue;
    end
    // a register write in the same cycle wins over calibration
    if (isWrite(riuWrEn, riuAddr, LANE_GROUP_CONTROL_A_OFS)) begin
      state_d.controlA = riuWrData[CTRLA_W-1:0];
    end
    if (isWrite(riuWrEn, riuAddr, LANE_GROUP_CONTROL_B_OFS)) begin
      state_d.controlB = riuWrData[CTRLB_W-1:0];
    end
    state_d.readyStatus  = fixedDelayReady;
    state_d.rdData       = regView(riuAddr, state_q.controlA, state_q.controlB, state_q.readyStatus);
    // outputs follow the stored bits one cycle later so each is a plain flop
    state_d.rxGate       = state_q.controlA[RX_GATE_POS];
    state_d.txGate       = state_q.controlA[TX_GATE_POS];
    state_d.serialSample = state_q.controlA[SERIAL_SAMPLE_POS];
    state_d.invertRx     = state_q.controlA[INVERT_RX_CLK_POS];
    state_d.negNeighbor  = state_q.controlA[NEG_NEIGHBOR_POS];
    state_d.posNeighbor  = state_q.controlA[POS_NEIGHBOR_POS];
    state_d.txPhase      = state_q.controlB[TX_PHASE_MSB:TX_PHASE_LSB];
    state_d.rxPhaseNeg   = state_q.controlB[RX_PHASE_NEG_POS];
    state_d.rxPhasePos   = state_q.controlB[RX_PHASE_POS_POS];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= BANK_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign riuRdData             = state_q.rdData;
  assign rxGateEn              = state_q.rxGate;
  assign txGateEn              = state_q.txGate;
  assign serialSampleEn        = state_q.serialSample;
  assign invertRxClk           = state_q.invertRx;
  assign negStrobeFromNeighbor = state_q.negNeighbor;
  assign posStrobeFromNeighbor = state_q.posNeighbor;
  assign txDataPhase           = state_q.txPhase;
  assign rxClkPhaseNeg         = state_q.rxPhaseNeg;
  assign rxClkPhasePos         = state_q.rxPhasePos;

  // checks: writes reach the outputs one edge after the write edge, so the checks sample them two edges on

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence writeA;
    riuWrEn && riuAddr == LANE_GROUP_CONTROL_A_OFS;
  endsequence

  sequence writeB;
    riuWrEn && riuAddr == LANE_GROUP_CONTROL_B_OFS;
  endsequence

  sequence readStatus;
    riuAddr == CAL_STATUS_OFS;
  endsequence

  rx_gate_a: assert property (
    writeA |-> ##2 rxGateEn == $past(riuWrData[RX_GATE_POS], 2))
    else $error("receive gating enable does not follow write");

  tx_gate_a: assert property (
    writeA |-> ##2 txGateEn == $past(riuWrData[TX_GATE_POS], 2))
    else $error("transmit gating enable does not follow write");

  serial_write_a: assert property (
    (writeA and riuWrData[SERIAL_SAMPLE_POS]) |-> ##2 serialSampleEn)
    else $error("serial sampling not enabled after write of one");

  serial_cal_a: assert property (
    (calSerialWrEn && !(riuWrEn && riuAddr == LANE_GROUP_CONTROL_A_OFS))
      |-> ##2 serialSampleEn == $past(calSerialValue, 2))
    else $error("calibration update of serial bit lost");

  ready_status_a: assert property (
    readStatus |-> ##1 riuRdData[FIXED_DELAY_READY_POS] == $past(state_q.readyStatus))
    else $error("fixed delay ready status misreported");

  ready_sync_a: assert property (
    $rose(fixedDelayReady) |-> ##1 state_q.readyStatus)
    else $error("ready status not captured");

  invert_rx_a: assert property (
    writeA |-> ##2 invertRxClk == $past(riuWrData[INVERT_RX_CLK_POS], 2))
    else $error("receive clock inversion does not follow write");

  neg_neighbor_a: assert property (
    (writeA and riuWrData[NEG_NEIGHBOR_POS]) |-> ##2 negStrobeFromNeighbor)
    else $error("negative delay not fed from neighbour");

  neg_own_a: assert property (
    (writeA and !riuWrData[NEG_NEIGHBOR_POS]) |-> ##2 !negStrobeFromNeighbor)
    else $error("negative delay not fed from own gating");

  pos_source_a: assert property (
    writeA |-> ##2 posStrobeFromNeighbor == $past(riuWrData[POS_NEIGHBOR_POS], 2))
    else $error("positive delay source does not follow write");

  tx_phase_a: assert property (
    writeB |-> ##2 txDataPhase == $past(riuWrData[TX_PHASE_MSB:TX_PHASE_LSB], 2))
    else $error("output data phase field does not follow write");

  slice_map_a: assert property (
    writeB |-> ##2 (txDataPhase[TX_PHASE_MDATA_POS] == $past(riuWrData[11], 2))
      && (txDataPhase[TX_PHASE_MCLK_POS] == $past(riuWrData[10], 2))
      && (txDataPhase[TX_PHASE_TRI_POS] == $past(riuWrData[9], 2))
      && (txDataPhase[TX_PHASE_SLICE_W-1:0] == $past(riuWrData[8:2], 2)))
    else $error("output data phase slice mapping wrong");

  rx_phase_a: assert property (
    writeB |-> ##2 rxClkPhaseNeg == $past(riuWrData[RX_PHASE_NEG_POS], 2)
      && rxClkPhasePos == $past(riuWrData[RX_PHASE_POS_POS], 2))
    else $error("input clock phase bits do not follow write");

  controls_hold_a: assert property (
    (!riuWrEn && !calSerialWrEn)[*3] |-> $stable(rxGateEn) && $stable(serialSampleEn)
      && $stable(txDataPhase))
    else $error("controls changed without a write");

  readback_a: assert property (
    writeB ##1 (riuAddr == LANE_GROUP_CONTROL_B_OFS && !riuWrEn)
      |-> ##1 riuRdData == {4'h0, $past(riuWrData[CTRLB_W-1:0], 2)})
    else $error("control b readback mismatch");

  sequence resetDone;
    $fell(rst);
  endsequence

  reset_ctrl_a: assert property (
    resetDone |-> {rxGateEn, txGateEn, serialSampleEn, invertRxClk, negStrobeFromNeighbor,
      posStrobeFromNeighbor} == CTRLA_RESET)
    else $error("control outputs not at reset value");

  reset_phase_a: assert property (
    resetDone |-> {txDataPhase, rxClkPhaseNeg, rxClkPhasePos} == CTRLB_RESET)
    else $error("phase outputs not at reset value");

  reset_read_a: assert property (
    resetDone |-> riuRdData == UNMAPPED_READ)
    else $error("read data not cleared by reset");

  ctrla_hold_a: assert property (
    !(riuWrEn && riuAddr == LANE_GROUP_CONTROL_A_OFS) && !calSerialWrEn |=> $stable(state_q.controlA))
    else $error("control a changed without a write");

  ctrlb_hold_a: assert property (
    !(riuWrEn && riuAddr == LANE_GROUP_CONTROL_B_OFS) |=> $stable(state_q.controlB))
    else $error("control b changed without a write");

  ctrla_reserved_a: assert property (
    riuAddr == LANE_GROUP_CONTROL_A_OFS |=> riuRdData[DATA_W-1:CTRLA_W] == '0)
    else $error("control a reserved bits not zero");

  ctrlb_reserved_a: assert property (
    riuAddr == LANE_GROUP_CONTROL_B_OFS |=> riuRdData[DATA_W-1:CTRLB_W] == '0)
    else $error("control b reserved bits not zero");

  status_only_a: assert property (
    readStatus |=> riuRdData[DATA_W-1:FIXED_DELAY_READY_POS+1] == '0
      && riuRdData[FIXED_DELAY_READY_POS-1:0] == '0)
    else $error("status register shows more than ready");

  unmapped_read_a: assert property (
    riuAddr != LANE_GROUP_CONTROL_A_OFS && riuAddr != LANE_GROUP_CONTROL_B_OFS && riuAddr != CAL_STATUS_OFS
      |=> riuRdData == UNMAPPED_READ)
    else $error("unmapped address does not read zero");

  ctrla_readback_a: assert property (
    writeA ##1 (riuAddr == LANE_GROUP_CONTROL_A_OFS && !riuWrEn)
      |-> ##1 riuRdData[CTRLA_W-1:0] == $past(riuWrData[CTRLA_W-1:0], 2))
    else $error("control a readback mismatch");

  write_wins_a: assert property (
    (calSerialWrEn && riuWrEn && riuAddr == LANE_GROUP_CONTROL_A_OFS)
      |-> ##2 serialSampleEn == $past(riuWrData[SERIAL_SAMPLE_POS], 2))
    else $error("calibration beat a register write");

  cal_bit_a: assert property (
    calSerialWrEn && !(riuWrEn && riuAddr == LANE_GROUP_CONTROL_A_OFS)
      |=> state_q.controlA[SERIAL_SAMPLE_POS] == $past(calSerialValue))
    else $error("calibration write of serial bit not stored");

  // calibration owns only the serial bit; the other controls stay as software left them
  cal_others_a: assert property (
    calSerialWrEn && !(riuWrEn && riuAddr == LANE_GROUP_CONTROL_A_OFS)
      |=> {state_q.controlA[CTRLA_W-1:SERIAL_SAMPLE_POS+1], state_q.controlA[SERIAL_SAMPLE_POS-1:0]}
        == $past({state_q.controlA[CTRLA_W-1:SERIAL_SAMPLE_POS+1], state_q.controlA[SERIAL_SAMPLE_POS-1:0]}))
    else $error("calibration write disturbed other controls");

  // the status flop sits one plain stage behind the synchroniser
  ready_track_a: assert property (
    state_q.readyStatus == $past(fixedDelayReady))
    else $error("ready status does not track synchroniser");

  ready_clear_a: assert property (
    $fell(fixedDelayReady) |=> !state_q.readyStatus)
    else $error("ready status not cleared");

  controls_keep_a: assert property (
    (!riuWrEn && !calSerialWrEn)[*3] |-> $stable(txGateEn) && $stable(invertRxClk)
      && $stable(negStrobeFromNeighbor) && $stable(posStrobeFromNeighbor)
      && $stable(rxClkPhaseNeg) && $stable(rxClkPhasePos))
    else $error("other controls changed without a write");

endmodule : lane_group_clocking_control
`default_nettype wire

/* lane_group_pkg.sv */
// constants for the lane group clocking control register bank
package lane_group_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] LANE_GROUP_CONTROL_A_OFS = 6'h00;
  localparam logic [ADDR_W-1:0] LANE_GROUP_CONTROL_B_OFS = 6'h01;
  localparam logic [ADDR_W-1:0] CAL_STATUS_OFS           = 6'h02;

  // lane_group_control_a fields
  localparam int CTRLA_W            = 6;
  localparam int RX_GATE_POS        = 5;
  localparam int TX_GATE_POS        = 4;
  localparam int SERIAL_SAMPLE_POS  = 3;
  localparam int INVERT_RX_CLK_POS  = 2;
  localparam int NEG_NEIGHBOR_POS   = 1;
  localparam int POS_NEIGHBOR_POS   = 0;
  localparam logic [CTRLA_W-1:0] CTRLA_RESET = 6'h03;

  // lane_group_control_b fields
  localparam int CTRLB_W            = 12;
  localparam int TX_PHASE_LSB       = 2;
  localparam int TX_PHASE_MSB       = 11;
  localparam int TX_PHASE_W         = 10;
  localparam int TX_PHASE_MDATA_POS = 9;
  localparam int TX_PHASE_MCLK_POS  = 8;
  localparam int TX_PHASE_TRI_POS   = 7;
  localparam int TX_PHASE_SLICE_W   = 7;
  localparam int RX_PHASE_NEG_POS   = 1;
  localparam int RX_PHASE_POS_POS   = 0;
  localparam logic [CTRLB_W-1:0] CTRLB_RESET = 12'h003;

  // calibration status field
  localparam int FIXED_DELAY_READY_POS = 11;

  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

endpackage : lane_group_pkg

/* level_sync3.sv */
// three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module level_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  typedef struct packed {
    logic meta;
    logic stage2;
    logic stage3;
    logic level;
  } syncState_t;

  syncState_t state_q;
  syncState_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.meta   = asyncIn;
    state_d.stage2 = state_q.meta;
    state_d.stage3 = state_q.stage2;
    // a change is taken only once two settled stages agree
    if (state_q.stage2 == state_q.stage3) begin
      state_d.level = state_q.stage3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.level;

endmodule : level_sync3
`default_nettype wire

/* riu_controller.sv */
// fabric controller model writing and reading through the register interface unit
`timescale 1ns/1ps
`default_nettype none
module riu_controller (
  input  wire logic                              clk_sys,
  output var  logic [lane_group_pkg::ADDR_W-1:0] riuAddr,
  output var  logic                              riuWrEn,
  output var  logic [lane_group_pkg::DATA_W-1:0] riuWrData,
  input  wire logic [lane_group_pkg::DATA_W-1:0] riuRdData
);
  import lane_group_pkg::*;
  initial begin
    riuAddr = 6'h3f;
    riuWrEn = 1'b0;
    riuWrData = 16'h5a5a;
  end
  // data is inverted once released so a stale value never looks valid
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    #1;
    riuAddr = a;
    riuWrData = d;
    riuWrEn = 1'b1;
    @(posedge clk_sys);
    #1;
    riuWrEn = 1'b0;
    riuWrData = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    #1;
    riuAddr = a;
    @(posedge clk_sys);
    #1;
    d = riuRdData;
  endtask : read_reg
  // polls the ready status, then rewrites the serial bit; bounded wait
  task automatic rewrite_serial(output bit ok);
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] a;
    ok = 1'b0;
    read_reg(LANE_GROUP_CONTROL_A_OFS, a);
    for (int i = 0; i < 32 && !ok; i++) begin
      read_reg(CAL_STATUS_OFS, d);
      ok = (d[FIXED_DELAY_READY_POS] === 1'b1);
    end
    if (ok) write_reg(LANE_GROUP_CONTROL_A_OFS, a | 16'h0008);
  endtask : rewrite_serial
endmodule : riu_controller
`default_nettype wire

/* testbench.sv */
// self-checking testbench for the lane group clocking control bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lane_group_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] riuAddr;
  logic riuWrEn;
  logic [DATA_W-1:0] riuWrData;
  logic [DATA_W-1:0] riuRdData;
  logic calSerialWrEn = 1'b0;
  logic calSerialValue = 1'b0;
  logic fixedDelayCalDone = 1'b0;
  logic rxGateEn, txGateEn, serialSampleEn, invertRxClk;
  logic negStrobeFromNeighbor, posStrobeFromNeighbor, rxClkPhaseNeg, rxClkPhasePos;
  logic [TX_PHASE_W-1:0] txDataPhase;
  int mismatches = 0;
  int nTests = 0;
  always #20 clk_sys = ~clk_sys;
  lane_group_clocking_control i_dut (.clk_sys(clk_sys), .rst(rst), .riuAddr(riuAddr), .riuWrEn(riuWrEn),
    .riuWrData(riuWrData), .riuRdData(riuRdData), .calSerialWrEn(calSerialWrEn), .calSerialValue(calSerialValue),
    .fixedDelayCalDone(fixedDelayCalDone), .rxGateEn(rxGateEn), .txGateEn(txGateEn),
    .serialSampleEn(serialSampleEn), .invertRxClk(invertRxClk), .negStrobeFromNeighbor(negStrobeFromNeighbor),
    .posStrobeFromNeighbor(posStrobeFromNeighbor), .txDataPhase(txDataPhase), .rxClkPhaseNeg(rxClkPhaseNeg),
    .rxClkPhasePos(rxClkPhasePos));
  riu_controller i_ctrl (.clk_sys(clk_sys), .riuAddr(riuAddr), .riuWrEn(riuWrEn), .riuWrData(riuWrData),
    .riuRdData(riuRdData));
  wire logic [5:0] outA = {rxGateEn, txGateEn, serialSampleEn, invertRxClk, negStrobeFromNeighbor,
    posStrobeFromNeighbor};
  wire logic [11:0] outB = {txDataPhase, rxClkPhaseNeg, rxClkPhasePos};
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finalReport();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finalReport
  // writes a register, reads it back and compares outputs
  task automatic wr_rd(input logic [5:0] a, input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] r;
    i_ctrl.write_reg(a, d);
    i_ctrl.read_reg(a, r);
    chk("readback", exp, r);
    chk("outputs", exp, (a == 6'h00) ? {10'h000, outA} : {4'h0, outB});
  endtask : wr_rd
  task automatic t_reset();
    logic [15:0] r;
    chk("reset out a", 16'h0003, {10'h000, outA});
    chk("reset out b", 16'h0003, {4'h0, outB});
    i_ctrl.read_reg(LANE_GROUP_CONTROL_A_OFS, r);
    chk("reset ctrl a", 16'h0003, r);
    i_ctrl.read_reg(LANE_GROUP_CONTROL_B_OFS, r);
    chk("reset ctrl b", 16'h0003, r);
    i_ctrl.read_reg(CAL_STATUS_OFS, r);
    chk("status idle", 16'h0000, r);
  endtask : t_reset
  task automatic t_ctrl_a();
    for (int i = 0; i < 6; i++) wr_rd(6'h00, 16'h0001 << i, 16'h0001 << i);
    wr_rd(6'h00, 16'h0000, 16'h0000);
    wr_rd(6'h00, 16'hffff, 16'h003f);
  endtask : t_ctrl_a
  task automatic t_ctrl_b();
    for (int i = 0; i < 12; i++) wr_rd(6'h01, 16'h0001 << i, 16'h0001 << i);
    wr_rd(6'h01, 16'hffff, 16'h0fff);
  endtask : t_ctrl_b
  task automatic t_refused();
    logic [15:0] r;
    wr_rd(6'h00, 16'h0015, 16'h0015);
    i_ctrl.write_reg(CAL_STATUS_OFS, 16'hffff);
    i_ctrl.write_reg(6'h3f, 16'hffff);
    i_ctrl.read_reg(LANE_GROUP_CONTROL_A_OFS, r);
    chk("ctrl a kept", 16'h0015, r);
    i_ctrl.read_reg(6'h3f, r);
    chk("unmapped", 16'h0000, r);
  endtask : t_refused
  task automatic cal_pulse(input logic v);
    @(posedge clk_sys);
    #1;
    calSerialWrEn = 1'b1;
    calSerialValue = v;
    @(posedge clk_sys);
    #1;
    calSerialWrEn = 1'b0;
    calSerialValue = ~v;
  endtask : cal_pulse
  task automatic t_cal();
    logic [15:0] r;
    wr_rd(6'h00, 16'h0000, 16'h0000);
    cal_pulse(1'b1);
    @(posedge clk_sys);
    #1;
    chk("cal serial", 16'h0001, {15'h0000, serialSampleEn});
    // register write and calibration write collide; the register wins
    fork
      i_ctrl.write_reg(LANE_GROUP_CONTROL_A_OFS, 16'h0000);
      cal_pulse(1'b1);
    join
    i_ctrl.read_reg(LANE_GROUP_CONTROL_A_OFS, r);
    chk("collision", 16'h0000, r);
    chk("collision out", 16'h0000, {15'h0000, serialSampleEn});
  endtask : t_cal
  task automatic t_ready();
    logic [15:0] r;
    bit ok;
    cal_pulse(1'b0);
    fixedDelayCalDone = 1'b1;
    i_ctrl.rewrite_serial(ok);
    if (!ok) begin
      mismatches++;
      $display("[FAIL] ready wait expected 1 seen 0");
      finalReport();
    end
    i_ctrl.read_reg(CAL_STATUS_OFS, r);
    chk("status ready", 16'h0800, r);
    i_ctrl.read_reg(LANE_GROUP_CONTROL_A_OFS, r);
    chk("serial rewritten", 16'h0008, r);
    chk("serial out", 16'h0001, {15'h0000, serialSampleEn});
  endtask : t_ready
  // ready level drops, then a second reset in mid-run must restore every default
  task automatic t_reset_mid();
    logic [15:0] r;
    wr_rd(6'h01, 16'h0ffc, 16'h0ffc);
    fixedDelayCalDone = 1'b0;
    repeat (8) @(posedge clk_sys);
    i_ctrl.read_reg(CAL_STATUS_OFS, r);
    chk("status dropped", 16'h0000, r);
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
  endtask : t_reset_mid
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_ctrl_a();
    t_ctrl_b();
    t_refused();
    t_cal();
    t_ready();
    t_reset_mid();
    finalReport();
  end
endmodule : testbench
`default_nettype wire
